/* File: hw/table_search_top.sv */
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Overview of operation
// - Writing one to the go bit of the control register starts a walk through every table entry in order.
// - Each valid entry met by the walk is loaded into the result registers (data, MAC address, VLAN id).
// - After a found entry the walk pauses and resumes only once the data result register is read.
// - The go bit clears itself when the whole table has been walked, so software can poll it.
// - The found flag in the control register is set whenever the walk presents an entry.
// - The found flag returns to zero when software reads the data result register.
// - Reserved control bits are written as zero and read back as zero.
// - The pointer valid bit is high while the low bits hold the pointer of the entry being visited.
// - The low fifteen bits of the pointer register show the entry location currently visited.
// - That pointer is an internal encoding, meant for diagnostic observation only.
// - The data result register carries the entry valid bit, and reading it clears the stored data.
// - The MAC/VID result registers hold the VLAN id and MAC address of the found entry, read only.
module table_search_top
   import search_pkg::*;
#(
   parameter int unsigned TABLE_AW = 11
) (
   // clock and reset
   input  wire logic                       core_clk_i,
   input  wire logic                       nrst_i,
   // ahb-lite slave
   input  wire logic                       hsel_i,
   input  wire logic [31:0]                haddr_i,
   input  wire logic [1:0]                 htrans_i,
   input  wire logic                       hwrite_i,
   input  wire logic [2:0]                 hsize_i,
   input  wire logic [31:0]                hwdata_i,
   input  wire logic                       hready_i,
   output logic      [31:0]                hrdata_o,
   output logic                            hreadyout_o,
   output logic                            hresp_o,
   // lookup table read port
   output logic                            tbl_rd_o,
   output logic      [TABLE_AW-1:0]        tbl_addr_o,
   input  wire logic                       tbl_ack_i,
   input  wire logic                       tbl_valid_i,
   input  wire logic [search_pkg::MAC_W-1:0]  tbl_mac_i,
   input  wire logic [search_pkg::VID_W-1:0]  tbl_vid_i,
   input  wire logic [search_pkg::DATA_W-1:0] tbl_data_i,
   // interrupt
   output logic                            irq_o
);
   import search_pkg::*;

   walk_if #(.AW(TABLE_AW)) wif ();

   // bus pipeline
   logic              acc;
   logic              wr_pend;
   logic              rd_busy;
   logic [7:0]        a_idx;
   logic              a_ok;
   logic              wr_fire;
   logic              rd_fire;

   // register state
   logic              go;
   logic              found_flag;
   logic              result_entry_valid;
   logic [DATA_W-1:0] result_data;
   logic [MAC_W-1:0]  result_mac_address;
   logic [VID_W-1:0]  result_vlan_id;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_mask;
   logic [IRQ_W-1:0]  irq_event;

   // decoded side effects
   logic              start_walk;
   logic              data_read;
   logic              stat_read;
   logic [PTR_W-1:0]  walk_pointer;
   logic              walk_pointer_valid;

   function automatic logic hits(input logic [7:0] idx, input logic ok, input logic [7:0] reg_idx);
      hits = ok && (idx == reg_idx);
   endfunction

   function automatic logic addr_ok(input logic [31:0] a);
      addr_ok = (a[31:10] == 22'h00_0000) && (a[1:0] == 2'h0);
   endfunction

   // ------------------------------------------------------------------
   // walk engine
   // ------------------------------------------------------------------
   table_walker #(
      .TABLE_AW (TABLE_AW)
   ) u_walker (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .wif        (wif.walker)
   );

   assign wif.start        = start_walk;
   assign wif.release_hold = data_read;
   assign wif.tbl_ack      = tbl_ack_i;
   assign wif.tbl_valid    = tbl_valid_i;

   assign tbl_rd_o   = wif.tbl_rd;
   assign tbl_addr_o = wif.tbl_addr;

   // ------------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------------
   // reads take one wait state so the read mux always sees a write that
   // finished in the cycle before; writes complete with no wait
   assign acc         = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
   assign hreadyout_o = !rd_busy;
   assign hresp_o     = 1'b0;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_idx <= 8'h00;
         a_ok  <= 1'b0;
      end else if (acc) begin
         a_idx <= haddr_i[9:2];
         a_ok  <= addr_ok(haddr_i);
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_pend <= 1'b0;
      end else begin
         wr_pend <= acc && hwrite_i && (hsize_i == HSIZE_WORD);
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_busy <= 1'b0;
      end else if (rd_busy) begin
         rd_busy <= 1'b0;
      end else begin
         rd_busy <= acc && !hwrite_i;
      end
   end

   assign wr_fire = wr_pend;
   assign rd_fire = rd_busy;

   // read side effects fire once, in the wait cycle of the read
   assign data_read = rd_fire && hits(a_idx, a_ok, IDX_DATA);
   assign stat_read = rd_fire && hits(a_idx, a_ok, IDX_IRQ_STAT);

   // a start is only honoured while no walk is running
   assign start_walk = wr_fire && hits(a_idx, a_ok, IDX_CTRL) &&
                       hwdata_i[CTRL_GO_BIT] && !go && !wif.busy;

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         go <= CTRL_RESET[CTRL_GO_BIT];
      end else if (start_walk) begin
         go <= 1'b1;
      end else if (wif.done) begin
         go <= 1'b0;
      end
      // a written zero is not a clear path here, so a walk cannot be aborted
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         found_flag <= CTRL_RESET[CTRL_FOUND_BIT];
      end else if (wif.found) begin
         found_flag <= 1'b1;
      end else if (data_read) begin
         found_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // result registers
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         result_entry_valid <= 1'b0;
         result_data        <= '0;
      end else if (wif.found) begin
         result_entry_valid <= 1'b1;
         result_data        <= tbl_data_i;
      end else if (data_read) begin
         result_entry_valid <= 1'b0;
         result_data        <= '0;
      end
   end

   // mac and vlan id stay put after the data read; only a new hit replaces them
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         result_mac_address <= '0;
         result_vlan_id     <= '0;
      end else if (wif.found) begin
         result_mac_address <= tbl_mac_i;
         result_vlan_id     <= tbl_vid_i;
      end
   end

   // ------------------------------------------------------------------
   // diagnostic pointer
   // ------------------------------------------------------------------
   assign walk_pointer       = wif.ptr;
   assign walk_pointer_valid = wif.busy;

   // ------------------------------------------------------------------
   // interrupts
   // ------------------------------------------------------------------
   always_comb begin
      irq_event                = '0;
      irq_event[IRQ_FOUND_BIT] = wif.found;
      irq_event[IRQ_DONE_BIT]  = wif.done;
   end

   // an event in the same cycle as the clearing read still lands
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_status <= IRQ_RESET;
      end else if (stat_read) begin
         irq_status <= irq_event;
      end else begin
         irq_status <= irq_status | irq_event;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_mask <= IRQ_RESET;
      end else if (wr_fire && hits(a_idx, a_ok, IDX_IRQ_MASK)) begin
         irq_mask <= hwdata_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ------------------------------------------------------------------
   // read data
   // ------------------------------------------------------------------
   function automatic logic [31:0] read_mux(input logic [7:0] idx, input logic ok);
      logic [31:0] v;
      v = WORD_ZERO;
      if (ok) begin
         case (idx)
            IDX_CTRL: begin
               // reserved bits read as zero
               v[CTRL_GO_BIT]    = go;
               v[CTRL_FOUND_BIT] = found_flag;
            end
            IDX_PTR: begin
               v[PTR_W-1:0]      = walk_pointer;
               v[PTR_VALID_BIT]  = walk_pointer_valid;
            end
            IDX_MACVID_LO: v = result_mac_address[31:0];
            IDX_MACVID_HI: v = {4'h0, result_vlan_id, result_mac_address[MAC_W-1:32]};
            IDX_DATA: begin
               v[DATA_W-1:0]     = result_data;
               v[RES_VALID_BIT]  = result_entry_valid;
            end
            IDX_IRQ_STAT: v[IRQ_W-1:0] = irq_status;
            IDX_IRQ_MASK: v[IRQ_W-1:0] = irq_mask;
            default:      v = WORD_ZERO;
         endcase
      end
      read_mux = v;
   endfunction

   // the value is taken before this cycle's clearing read takes effect
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hrdata_o <= WORD_ZERO;
      end else if (rd_busy) begin
         hrdata_o <= read_mux(a_idx, a_ok);
      end
   end

endmodule // table_search_top

/* File: common/search_pkg.sv */
package search_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL      = 8'h50;
   localparam logic [7:0] IDX_PTR       = 8'h51;
   localparam logic [7:0] IDX_MACVID_LO = 8'h60;
   localparam logic [7:0] IDX_MACVID_HI = 8'h61;
   localparam logic [7:0] IDX_DATA      = 8'h68;
   localparam logic [7:0] IDX_IRQ_STAT  = 8'h80;
   localparam logic [7:0] IDX_IRQ_MASK  = 8'h81;

   // field positions
   localparam int unsigned CTRL_GO_BIT    = 7;
   localparam int unsigned CTRL_FOUND_BIT = 0;
   localparam int unsigned PTR_VALID_BIT  = 15;
   localparam int unsigned RES_VALID_BIT  = 16;
   localparam int unsigned IRQ_FOUND_BIT  = 0;
   localparam int unsigned IRQ_DONE_BIT   = 1;

   // widths
   localparam int unsigned MAC_W  = 48;
   localparam int unsigned VID_W  = 12;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned PTR_W  = 15;
   localparam int unsigned IRQ_W  = 2;

   // reset values
   localparam logic [7:0]        CTRL_RESET = 8'h00;
   localparam logic [15:0]       PTR_RESET  = 16'h0000;
   localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;
   localparam logic [31:0]       WORD_ZERO  = 32'h0000_0000;

   // bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;

   typedef enum logic [2:0] {
      WALK_IDLE = 3'h0,
      WALK_READ = 3'h1,
      WALK_WAIT = 3'h3,
      WALK_HOLD = 3'h2,
      WALK_END  = 3'h6
   } walk_state_t;

endpackage

/* File: common/walk_if.sv */
`timescale 1ns/1ps
interface walk_if #(parameter int unsigned AW = 11);
   logic                          start;
   logic                          release_hold;
   logic                          found;
   logic                          done;
   logic                          busy;
   logic [search_pkg::PTR_W-1:0]  ptr;
   logic                          tbl_rd;
   logic [AW-1:0]                 tbl_addr;
   logic                          tbl_ack;
   logic                          tbl_valid;

   modport ctrl (output start, output release_hold, output tbl_ack, output tbl_valid,
                 input found, input done, input busy, input ptr, input tbl_rd, input tbl_addr);
   modport walker (input start, input release_hold, input tbl_ack, input tbl_valid,
                   output found, output done, output busy, output ptr, output tbl_rd, output tbl_addr);
endinterface

/* File: hw/table_walker.sv */
`timescale 1ns/1ps
module table_walker #(
   parameter int unsigned TABLE_AW = 11
) (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   // control side
   walk_if.walker    wif
);
   import search_pkg::*;

   walk_state_t          state;
   walk_state_t          next_state;
   logic [TABLE_AW-1:0]  idx;
   logic                 last;
   logic                 hit;
   logic                 advance;
   logic [PTR_W-1:0]     idx_wide;

   assign last = (idx == {TABLE_AW{1'b1}});
   assign hit  = (state == WALK_WAIT) && wif.tbl_ack && wif.tbl_valid;
   assign advance = ((state == WALK_WAIT) && wif.tbl_ack && !wif.tbl_valid && !last) ||
                    ((state == WALK_HOLD) && wif.release_hold && !last);

   always_comb begin
      next_state = state;
      case (state)
         WALK_IDLE: if (wif.start) next_state = WALK_READ;
         WALK_READ: next_state = WALK_WAIT;
         WALK_WAIT: begin
            if (wif.tbl_ack) begin
               if (wif.tbl_valid) next_state = WALK_HOLD;
               else if (last) next_state = WALK_END;
               else next_state = WALK_READ;
            end
         end
         WALK_HOLD: begin
            if (wif.release_hold) next_state = last ? WALK_END : WALK_READ;
         end
         WALK_END:  next_state = WALK_IDLE;
         default:   next_state = WALK_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) state <= WALK_IDLE;
      else state <= next_state;
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) idx <= '0;
      else if (state == WALK_IDLE && wif.start) idx <= '0;
      else if (advance) idx <= idx + 1'b1;
   end

   // the pointer is shown gray coded, not as a plain table index
   assign idx_wide     = PTR_W'(idx);
   assign wif.ptr      = idx_wide ^ (idx_wide >> 1);
   assign wif.tbl_rd   = (state == WALK_READ);
   assign wif.tbl_addr = idx;
   assign wif.found    = hit;
   assign wif.done     = (state == WALK_END);
   assign wif.busy     = (state != WALK_IDLE);

endmodule // table_walker

/* File: tb/table_search_asserts.sv */
`timescale 1ns/1ps
module table_search_asserts
   import search_pkg::*;
#(
   parameter int unsigned TABLE_AW = 11
) (
   // clock and reset
   input wire logic                core_clk_i,
   input wire logic                nrst_i,
   // bus
   input wire logic                hsel_i,
   input wire logic [1:0]          htrans_i,
   input wire logic                hwrite_i,
   input wire logic                hready_i,
   input wire logic [31:0]         hrdata_o,
   input wire logic                hreadyout_o,
   input wire logic                hresp_o,
   // table port
   input wire logic                tbl_rd_o,
   input wire logic [TABLE_AW-1:0] tbl_addr_o,
   input wire logic                tbl_ack_i,
   input wire logic                tbl_valid_i
);
   logic [TABLE_AW-1:0] last_addr;
   logic                take;

   assign take = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   // remembers the previous entry fetched, so the walk order can be checked
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_addr <= '0;
      end else if (tbl_rd_o) begin
         last_addr <= tbl_addr_o;
      end
   end

   a_resp_okay: assert property (hresp_o == 1'b0)
      else $error("bus response not okay");
   a_read_wait: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read data phase not one wait cycle");
   a_write_ready: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write data phase stalled");
   a_rdata_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
      else $error("read data changed outside a read");
   a_tbl_pulse: assert property (tbl_rd_o |=> !tbl_rd_o)
      else $error("table read longer than one cycle");
   a_addr_hold: assert property (tbl_rd_o |=> $stable(tbl_addr_o))
      else $error("table address moved during fetch");
   a_walk_order: assert property (tbl_rd_o && tbl_addr_o != '0 |-> tbl_addr_o == last_addr + 1'b1)
      else $error("walk skipped an entry");
   a_hit_pause: assert property (tbl_ack_i && tbl_valid_i |=> !tbl_rd_o [*3])
      else $error("walk did not pause on a hit");
   a_miss_gap: assert property (tbl_ack_i && !tbl_valid_i && tbl_addr_o != '1 |=> tbl_rd_o)
      else $error("walk did not move on after a miss");
endmodule // table_search_asserts

bind table_search_top table_search_asserts #(.TABLE_AW(TABLE_AW)) u_table_search_asserts (.*);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import search_pkg::*;
   localparam int unsigned AW = 3;
   logic core_clk_i = 1'b0, nrst_i = 1'b0;
   logic hsel_i = 1'b0, hwrite_i = 1'b0, tbl_ack_i = 1'b0, tbl_valid_i = 1'b0;
   logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, r;
   logic [1:0] htrans_i = '0;
   logic [2:0] hsize_i = HSIZE_WORD;
   logic hreadyout_o, hresp_o, tbl_rd_o, irq_o;
   logic [AW-1:0] tbl_addr_o;
   logic [MAC_W-1:0] tbl_mac_i = '0;
   logic [VID_W-1:0] tbl_vid_i = '0;
   logic [DATA_W-1:0] tbl_data_i = '0;
   int errors = 0, checks = 0, idx, hits[3] = '{1, 4, 7};

   table_search_top #(.TABLE_AW(AW)) u_table_search_top (.core_clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i,
      .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .tbl_rd_o,
      .tbl_addr_o, .tbl_ack_i, .tbl_valid_i, .tbl_mac_i, .tbl_vid_i, .tbl_data_i, .irq_o);

   always #12.5 core_clk_i = ~core_clk_i;

   function automatic logic [31:0] ba(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   function automatic logic [MAC_W-1:0] mac_of(input int i);
      return 48'h1234_5678_9A00 | 48'(i);
   endfunction

   // table model: acks one to three cycles late; fields hold only with the ack
   // the read strobe is looked at mid-cycle, clear of the edge that launches it
   always @(negedge core_clk_i) begin
      if (tbl_rd_o) begin
         idx = int'(tbl_addr_o);
         @(posedge core_clk_i);
         repeat (idx % 3) @(posedge core_clk_i);
         tbl_ack_i <= 1'b1;
         tbl_valid_i <= (idx == 1 || idx == 4 || idx == 7);
         tbl_mac_i <= mac_of(idx);
         tbl_vid_i <= 12'h100 | 12'(idx);
         tbl_data_i <= 16'hC000 | 16'(idx);
         @(posedge core_clk_i);
         tbl_ack_i <= 1'b0;
         tbl_valid_i <= 1'b0;
         tbl_mac_i <= ~tbl_mac_i;
         tbl_vid_i <= ~tbl_vid_i;
         tbl_data_i <= ~tbl_data_i;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      haddr_i <= a;
      htrans_i <= HTRANS_NONSEQ;
      hwrite_i <= wr;
      // ready is looked at mid-cycle; the following rising edge is the one that samples it high
      @(negedge core_clk_i);
      while (!hreadyout_o) @(negedge core_clk_i);
      @(posedge core_clk_i);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      @(negedge core_clk_i);
      while (!hreadyout_o) @(negedge core_clk_i);
      r = hrdata_o;
      @(posedge core_clk_i);
   endtask

   task automatic rd(input logic [7:0] i);
      bus(1'b0, ba(i), '0);
   endtask

   // polls a register until the masked bits take the wanted value
   task automatic poll(input logic [7:0] i, input logic [31:0] m, input logic [31:0] w);
      for (int n = 0; n < 60; n++) begin
         rd(i);
         if ((r & m) === w) break;
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (4000) @(posedge core_clk_i);
      errors++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      @(posedge core_clk_i);
      foreach (hits[k]) begin
         rd(k == 0 ? IDX_CTRL : k == 1 ? IDX_PTR : IDX_DATA);
         chk(r, WORD_ZERO, "reset value");
      end
      rd(8'hFF);
      chk(r, WORD_ZERO, "unmapped read");
      bus(1'b1, ba(IDX_CTRL), 32'h0000_007F);
      rd(IDX_CTRL);
      chk(r, WORD_ZERO, "reserved and go zero write");
      bus(1'b1, ba(IDX_IRQ_MASK), 32'h0000_0001);
      rd(IDX_IRQ_MASK);
      chk(r, 32'h0000_0001, "mask readback");
      $display("test registers done");

      bus(1'b1, ba(IDX_CTRL), 32'h0000_0080);
      foreach (hits[k]) begin
         poll(IDX_CTRL, 32'h0000_0001, 32'h0000_0001);
         chk(r, 32'h0000_0081, "found flag with go");
         chk(32'(irq_o), 32'h0000_0001, "irq on hit");
         rd(IDX_PTR);
         chk(r, 32'h8000 | 32'(hits[k] ^ (hits[k] >> 1)), "walk pointer");
         bus(1'b1, ba(IDX_CTRL), 32'h0000_0000);
         bus(1'b1, ba(IDX_MACVID_LO), 32'h0000_0000);
         rd(IDX_MACVID_LO);
         chk(r, 32'(mac_of(hits[k])), "mac low");
         rd(IDX_MACVID_HI);
         chk(r, {4'h0, 12'h100 | 12'(hits[k]), 16'(mac_of(hits[k]) >> 32)}, "vid mac high");
         rd(IDX_CTRL);
         chk(r, 32'h0000_0081, "go survives zero write");
         rd(IDX_IRQ_STAT);
         chk(r, 32'h0000_0001, "found status");
         rd(IDX_DATA);
         chk(r, 32'h0001_C000 | 32'(hits[k]), "data result");
         rd(IDX_CTRL);
         chk(r & 32'h0000_0001, WORD_ZERO, "found flag cleared");
         rd(IDX_DATA);
         chk(r, WORD_ZERO, "data cleared");
         chk(32'(irq_o), WORD_ZERO, "irq cleared");
      end
      $display("test walk hits done");

      poll(IDX_CTRL, 32'h0000_0080, WORD_ZERO);
      chk(r, WORD_ZERO, "go self clears");
      rd(IDX_PTR);
      chk(r & 32'h0000_8000, WORD_ZERO, "pointer invalid after walk");
      chk(32'(irq_o), WORD_ZERO, "done masked");
      bus(1'b1, ba(IDX_IRQ_MASK), 32'h0000_0003);
      repeat (2) @(posedge core_clk_i);
      chk(32'(irq_o), 32'h0000_0001, "done unmasked");
      rd(IDX_IRQ_STAT);
      chk(r, 32'h0000_0002, "done status");
      repeat (2) @(posedge core_clk_i);
      chk(32'(irq_o), WORD_ZERO, "status read clears");
      $display("test walk end done");
      print_verdict();
   end
endmodule // tb_top
